// >>> lvd_top.sv
`timescale 1ns/100ps
`include "lvd_cfg.svh"
module lvd_top (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // analog comparators, asynchronous
   input  wire logic        supply_below_raw,
   input  wire logic        ext_below_raw,
   // to analog side and system
   output logic             detector_on,
   output logic             source_select,
   output logic      [3:0]  threshold_code,
   output logic      [4:0]  port12_dir,
   output logic             below_threshold_flag,
   output logic             undervolt_irq,
   output logic             undervolt_irq_mask,
   output logic             undervolt_reset
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic                 on_ff;
   lvd_pkg::lvd_source_t src_ff;
   lvd_pkg::lvd_action_t act_ff;
   logic [7:0]           level_ff;
   logic [4:0]           p12_ff;
   logic                 mask_ff;
   logic                 cause_ff;
   logic                 flag_ff;
   logic                 qual_prev_ff;
   logic                 irq_ff;
   logic                 rst_ff;
   logic                 dp_valid_ff;
   logic                 dp_write_ff;
   logic [15:0]          dp_idx_ff;
   logic [31:0]          rdata_ff;

   logic                 nxt_on;
   lvd_pkg::lvd_source_t nxt_src;
   lvd_pkg::lvd_action_t nxt_act;
   logic [7:0]           nxt_level;
   logic [4:0]           nxt_p12;
   logic                 nxt_mask;
   logic                 nxt_cause;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic idx_hit(input logic [15:0] idx, input logic [15:0] want);
      idx_hit = (idx == want);
   endfunction

   wire        addr_ph   = hsel && hready && htrans[1];
   wire [15:0] ap_idx    = haddr[17:2];
   wire        ap_mapped = (haddr[31:18] == 14'h0000);
   wire        wr_now    = dp_valid_ff && dp_write_ff;
   wire        wr_ctl    = wr_now && idx_hit(dp_idx_ff, `LVD_IDX_CONTROL);
   wire        wr_lvl    = wr_now && idx_hit(dp_idx_ff, `LVD_IDX_LEVEL);
   wire        wr_p12    = wr_now && idx_hit(dp_idx_ff, `LVD_IDX_PORT12);
   wire        wr_cause  = wr_now && idx_hit(dp_idx_ff, `LVD_IDX_CAUSE);
   wire        wr_mask   = wr_now && idx_hit(dp_idx_ff, `LVD_IDX_MASK);
   wire [7:0]  wbyte     = hwdata[7:0];

   // ------------------------------------------------------------
   // comparator synchronisation and qualification
   // ------------------------------------------------------------
   logic [1:0] cmp_sync;

   lvd_sync #(
      .WIDTH (2)
   ) u_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .async_in ({ext_below_raw, supply_below_raw}),
      .sync_out (cmp_sync)
   );

   wire src_below = (src_ff == lvd_pkg::LVD_SRC_EXTERNAL) ? cmp_sync[1] : cmp_sync[0];
   wire below     = on_ff && src_below;
   // request when below in irq action
   wire qual_irq  = below && (act_ff == lvd_pkg::LVD_ACT_IRQ);
   // reset action holds reset while below
   wire want_rst  = below && (act_ff == lvd_pkg::LVD_ACT_RESET);

   // ------------------------------------------------------------
   // register next values
   // ------------------------------------------------------------
   always_comb begin
      nxt_on    = on_ff;
      nxt_src   = src_ff;
      nxt_act   = act_ff;
      nxt_level = level_ff;
      nxt_p12   = p12_ff;
      nxt_mask  = mask_ff;
      nxt_cause = cause_ff;
      if (rst_ff) begin
         nxt_level = `LVD_RST_LEVEL;
         nxt_p12   = 5'(`LVD_RST_PORT12);
         nxt_mask  = `LVD_RST_MASK;
      end else begin
         if (wr_ctl) begin
            nxt_on  = wbyte[`LVD_CTL_ON_BIT];
            nxt_src = lvd_pkg::lvd_source_t'(wbyte[`LVD_CTL_SRC_BIT]);
            nxt_act = lvd_pkg::lvd_action_t'(wbyte[`LVD_CTL_ACT_BIT]);
         end
         // full byte kept, low nibble is the code
         if (wr_lvl) begin
            nxt_level = wbyte;
         end
         if (wr_p12) begin
            nxt_p12 = wbyte[4:0];
         end
         if (wr_mask) begin
            nxt_mask = wbyte[`LVD_MASK_BIT];
         end
         if (wr_cause && wbyte[`LVD_CAUSE_LVD_BIT]) begin
            nxt_cause = 1'b0;
         end
      end
      if (rst_ff) begin
         nxt_cause = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // read mux, from next values so a write is seen at once
   // ------------------------------------------------------------
   wire [7:0] rd_ctl = {nxt_on, 4'h0, nxt_src, nxt_act, below};
   wire [7:0] rd_p12 = {`LVD_P12_FIXED, nxt_p12};
   wire [7:0] rd_byte =
      !ap_mapped                          ? 8'h00 :
      idx_hit(ap_idx, `LVD_IDX_CONTROL)   ? rd_ctl :
      idx_hit(ap_idx, `LVD_IDX_LEVEL)     ? nxt_level :
      idx_hit(ap_idx, `LVD_IDX_PORT12)    ? rd_p12 :
      idx_hit(ap_idx, `LVD_IDX_CAUSE)     ? {7'h00, nxt_cause} :
      idx_hit(ap_idx, `LVD_IDX_MASK)      ? {7'h00, nxt_mask} :
                                            8'h00;

   // ------------------------------------------------------------
   // bus pipeline
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dp_valid_ff <= 1'b0;
         dp_write_ff <= 1'b0;
         dp_idx_ff   <= 16'h0000;
         rdata_ff    <= 32'h0000_0000;
      end else begin
         dp_valid_ff <= addr_ph && ap_mapped;
         dp_write_ff <= hwrite;
         dp_idx_ff   <= ap_idx;
         rdata_ff    <= (addr_ph && !hwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // detector reset keeps control bits
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         on_ff  <= 1'b0;
         src_ff <= lvd_pkg::LVD_SRC_SUPPLY;
         act_ff <= lvd_pkg::LVD_ACT_IRQ;
      end else begin
         on_ff  <= nxt_on;
         src_ff <= nxt_src;
         act_ff <= nxt_act;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         level_ff <= `LVD_RST_LEVEL;
         p12_ff   <= 5'(`LVD_RST_PORT12);
         mask_ff  <= `LVD_RST_MASK;
         cause_ff <= 1'b0;
      end else begin
         level_ff <= nxt_level;
         p12_ff   <= nxt_p12;
         mask_ff  <= nxt_mask;
         cause_ff <= nxt_cause;
      end
   end

   // ------------------------------------------------------------
   // flag, interrupt and reset generation
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         flag_ff      <= 1'b0;
         qual_prev_ff <= 1'b0;
         irq_ff       <= 1'b0;
         rst_ff       <= 1'b0;
      end else begin
         flag_ff      <= below;
         qual_prev_ff <= qual_irq;
         irq_ff       <= qual_irq && !qual_prev_ff;
         rst_ff       <= want_rst;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign hrdata               = rdata_ff;
   assign hreadyout            = 1'b1;
   assign hresp                = 1'b0;
   assign detector_on          = on_ff;
   assign source_select        = src_ff;
   assign threshold_code       = level_ff[3:0];
   assign port12_dir           = p12_ff;
   assign below_threshold_flag = flag_ff;
   assign undervolt_irq        = irq_ff;
   assign undervolt_irq_mask   = mask_ff;
   assign undervolt_reset      = rst_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   chk_flag_follows: assert property (
      flag_ff == $past(on_ff && src_below))
      else $error("flag does not follow qualified comparator");

   chk_flag_disabled: assert property (
      !on_ff |=> !flag_ff)
      else $error("flag set while detector disabled");

   chk_ext_source: assert property (
      on_ff && src_ff == lvd_pkg::LVD_SRC_EXTERNAL && cmp_sync[1] |=> flag_ff)
      else $error("external comparator not reflected in flag");

   chk_irq_pulse: assert property (
      irq_ff |=> !irq_ff)
      else $error("interrupt pulse longer than one cycle");

   chk_irq_mode: assert property (
      irq_ff |-> $past(on_ff && act_ff == lvd_pkg::LVD_ACT_IRQ && src_below))
      else $error("interrupt outside interrupt action");

   chk_irq_rise: assert property (
      !qual_irq ##1 qual_irq |=> irq_ff)
      else $error("interrupt missing on falling source");

   chk_reset_below: assert property (
      want_rst |=> rst_ff)
      else $error("internal reset not asserted while below");

   chk_no_reset_above: assert property (
      !below |=> !rst_ff)
      else $error("internal reset while above threshold");

   chk_mask_on_reset: assert property (
      rst_ff |=> mask_ff)
      else $error("mask not set by detector reset");

   chk_cause_set: assert property (
      rst_ff |=> cause_ff)
      else $error("reset cause not recorded");

   chk_ctrl_kept: assert property (
      rst_ff |=> on_ff == $past(on_ff) && src_ff == $past(src_ff) && act_ff == $past(act_ff))
      else $error("control bits lost on detector reset");

   chk_level_clear: assert property (
      rst_ff |=> level_ff == 8'h00 && p12_ff == 5'h1F)
      else $error("level or direction not reset");

   chk_level_write: assert property (
      wr_lvl && !rst_ff |=> level_ff == $past(hwdata[7:0]))
      else $error("level register write lost");

   chk_level_hold: assert property (
      !wr_lvl && !rst_ff |=> $stable(level_ff))
      else $error("level register changed without write");

   chk_ctrl_write: assert property (
      wr_ctl && !rst_ff |=> {on_ff, src_ff, act_ff} ==
         $past({hwdata[`LVD_CTL_ON_BIT], hwdata[`LVD_CTL_SRC_BIT], hwdata[`LVD_CTL_ACT_BIT]}))
      else $error("control register write lost");

   chk_ctrl_read: assert property (
      addr_ph && !hwrite && ap_mapped && idx_hit(ap_idx, `LVD_IDX_CONTROL)
         |=> hrdata[6:3] == 4'h0 && hrdata[31:8] == 24'h000000)
      else $error("control read shows reserved bits set");

   chk_flag_read: assert property (
      addr_ph && !hwrite && ap_mapped && idx_hit(ap_idx, `LVD_IDX_CONTROL)
         |=> hrdata[`LVD_CTL_FLAG_BIT] == $past(on_ff && src_below))
      else $error("readable flag wrong");

   chk_p12_write: assert property (
      wr_p12 && !rst_ff |=> p12_ff == $past(hwdata[4:0]))
      else $error("direction register write lost");

   chk_p12_read: assert property (
      addr_ph && !hwrite && ap_mapped && idx_hit(ap_idx, `LVD_IDX_PORT12)
         |=> hrdata[7:5] == 3'h7)
      else $error("direction upper bits not read as one");

   chk_irq_quiet: assert property (
      !on_ff |=> !irq_ff)
      else $error("interrupt while detector disabled");

   chk_reset_action: assert property (
      act_ff == lvd_pkg::LVD_ACT_IRQ |=> !rst_ff)
      else $error("internal reset in interrupt action");

   chk_mask_hold: assert property (
      !wr_mask && !rst_ff |=> $stable(mask_ff))
      else $error("mask changed without write or reset");

   chk_cause_hold: assert property (
      cause_ff && !wr_cause |=> cause_ff)
      else $error("reset cause lost without clear");

endmodule

// >>> lvd_cfg.svh
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define LVD_IDX_PORT12   16'hFF2C
`define LVD_IDX_CONTROL  16'hFFBE
`define LVD_IDX_LEVEL    16'hFFBF
`define LVD_IDX_CAUSE    16'hFFC0
`define LVD_IDX_MASK     16'hFFC1

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LVD_CTL_ON_BIT     7
`define LVD_CTL_SRC_BIT    2
`define LVD_CTL_ACT_BIT    1
`define LVD_CTL_FLAG_BIT   0
`define LVD_CAUSE_LVD_BIT  0
`define LVD_MASK_BIT       0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LVD_RST_LEVEL    8'h00
`define LVD_RST_PORT12   8'hFF
`define LVD_P12_FIXED    3'h7
`define LVD_RST_MASK     1'h1

`endif

// >>> lvd_pkg.sv
package lvd_pkg;

   typedef enum logic {
      LVD_SRC_SUPPLY   = 1'b0,
      LVD_SRC_EXTERNAL = 1'b1
   } lvd_source_t;

   typedef enum logic {
      LVD_ACT_IRQ   = 1'b0,
      LVD_ACT_RESET = 1'b1
   } lvd_action_t;

   typedef logic [3:0] lvd_code_t;

endpackage

// >>> lvd_sync.sv
`timescale 1ns/100ps
module lvd_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;

   // first stage is read by the second stage only
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         meta_ff  <= '0;
         sync_out <= '0;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule

// >>> lvd_analog_model.sv
`timescale 1ns/100ps
module lvd_analog_model #(
   parameter int EXT_THR_MV = 1210
) (
   input  wire logic       detector_on,
   input  wire logic       source_select,
   input  wire logic [3:0] threshold_code,
   input  var  int         vdd_mv,
   input  var  int         ext_mv,
   output logic            supply_below_raw,
   output logic            ext_below_raw
);
   // ------------------------------------------------------------
   // comparator thresholds in millivolts, code 0 highest
   // ------------------------------------------------------------
   // sixteen supply thresholds
   localparam int THR_MV [16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
                                  3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};

   // ------------------------------------------------------------
   // comparators, only the selected one runs while enabled
   // ------------------------------------------------------------
   // strict below compare, fixed external level
   always_comb begin
      supply_below_raw = detector_on && !source_select && (vdd_mv < THR_MV[threshold_code]);
      ext_below_raw    = detector_on && source_select && (ext_mv < EXT_THR_MV);
   end
endmodule

// >>> test_low_voltage_detect_control.sv
`timescale 1ns/100ps
`include "lvd_cfg.svh"
module test_low_voltage_detect_control;
   logic        ref_clk = 1'b0;
   logic        resetn;
   logic        hsel;
   logic        hwrite;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic        hreadyout;
   logic        hresp;
   logic        sup_raw;
   logic        ext_raw;
   logic        detector_on;
   logic        source_select;
   logic        below_threshold_flag;
   logic        undervolt_irq;
   logic        undervolt_irq_mask;
   logic        undervolt_reset;
   logic [3:0]  threshold_code;
   logic [4:0]  port12_dir;
   int          vdd_mv;
   int          ext_mv;
   int          err_total;
   int          n_tests;
   int          irq_cnt = 0;
   int          n0;
   localparam int THR_MV [16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
                                  3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};

   always #2 ref_clk = ~ref_clk;

   always @(posedge ref_clk) if (undervolt_irq === 1'b1) irq_cnt++;

   lvd_top i_lvd_top (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .supply_below_raw(sup_raw),
      .ext_below_raw(ext_raw), .detector_on(detector_on), .source_select(source_select),
      .threshold_code(threshold_code), .port12_dir(port12_dir),
      .below_threshold_flag(below_threshold_flag), .undervolt_irq(undervolt_irq),
      .undervolt_irq_mask(undervolt_irq_mask), .undervolt_reset(undervolt_reset));

   lvd_analog_model i_lvd_analog_model (.detector_on(detector_on),
      .source_select(source_select), .threshold_code(threshold_code), .vdd_mv(vdd_mv),
      .ext_mv(ext_mv), .supply_below_raw(sup_raw), .ext_below_raw(ext_raw));

   // ------------------------------------------------------------
   // bus access and comparison
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] ax(input logic [15:0] idx);
      return {14'h0000, idx, 2'h0};
   endfunction

   task automatic bus(input logic [31:0] addr, input logic wr_en, input logic [7:0] wd);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= addr;
      htrans <= 2'h2;
      hwrite <= wr_en;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
      bus(ax(idx), 1'b1, wd);
   endtask

   task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input string what);
      bus(ax(idx), 1'b0, 8'h00);
      check(what, exp, rd);
   endtask

   // comparator edge passes two sync stages plus one output stage
   task automatic settle();
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic defaults();
      rdc(`LVD_IDX_CONTROL, 32'h00, "control reset");
      rdc(`LVD_IDX_LEVEL, 32'h00, "level reset");
      rdc(`LVD_IDX_PORT12, 32'hFF, "port12 reset");
      rdc(`LVD_IDX_MASK, 32'h01, "mask reset");
      rdc(`LVD_IDX_CAUSE, 32'h00, "cause reset");
      check("dir port", 32'h1F, {27'h0, port12_dir});
      check("mask port", 32'h1, {31'h0, undervolt_irq_mask});
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      test_done();
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; vdd_mv = 5000; ext_mv = 3000;
      err_total = 0; n_tests = 0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      defaults();
      $display("reset test ended");

      wr(`LVD_IDX_LEVEL, 8'h0F);
      rdc(`LVD_IDX_LEVEL, 32'h0F, "level rw");
      check("code port", 32'hF, {28'h0, threshold_code});
      wr(`LVD_IDX_PORT12, 8'h00);
      rdc(`LVD_IDX_PORT12, 32'hE0, "port12 rw");
      check("dir out", 32'h00, {27'h0, port12_dir});
      wr(`LVD_IDX_PORT12, 8'h01);
      @(posedge ref_clk);
      check("dir in", 32'h01, {27'h0, port12_dir});
      wr(`LVD_IDX_CONTROL, 8'h7F);
      rdc(`LVD_IDX_CONTROL, 32'h06, "control fields");
      wr(`LVD_IDX_CONTROL, 8'h00);
      bus(ax(16'h1234), 1'b1, 8'h55);
      rdc(16'h1234, 32'h00, "unmapped");
      bus(32'h0004_0000 | ax(`LVD_IDX_LEVEL), 1'b0, 8'h00);
      check("upper address", 32'h0, rd);
      check("response", 32'h0, {31'h0, hresp});
      rdc(`LVD_IDX_LEVEL, 32'h0F, "level kept");
      $display("register test ended");

      for (int c = 0; c < 16; c++) begin
         wr(`LVD_IDX_CONTROL, 8'h00);
         wr(`LVD_IDX_LEVEL, 8'(c));
         wr(`LVD_IDX_CONTROL, 8'h80);
         vdd_mv <= THR_MV[c] - 1;
         settle();
         rdc(`LVD_IDX_CONTROL, 32'h81, "flag below");
         vdd_mv <= THR_MV[c];
         settle();
         rdc(`LVD_IDX_CONTROL, 32'h80, "flag at level");
      end
      $display("threshold test ended");

      wr(`LVD_IDX_CONTROL, 8'h00);
      wr(`LVD_IDX_CONTROL, 8'h84);
      vdd_mv <= 1500;
      ext_mv <= 1209;
      settle();
      rdc(`LVD_IDX_CONTROL, 32'h85, "ext below");
      check("source port", 32'h1, {31'h0, source_select});
      ext_mv <= 1210;
      settle();
      rdc(`LVD_IDX_CONTROL, 32'h84, "ext at level");
      wr(`LVD_IDX_CONTROL, 8'h04);
      ext_mv <= 1000;
      settle();
      rdc(`LVD_IDX_CONTROL, 32'h04, "flag disabled");
      wr(`LVD_IDX_CONTROL, 8'h00);
      vdd_mv <= 5000;
      ext_mv <= 3000;
      $display("external test ended");

      wr(`LVD_IDX_LEVEL, 8'h00);
      wr(`LVD_IDX_CONTROL, 8'h80);
      settle();
      n0 = irq_cnt;
      vdd_mv <= 4000;
      repeat (10) @(posedge ref_clk);
      check("irq pulses", 32'h1, 32'(irq_cnt - n0));
      check("flag port", 32'h1, {31'h0, below_threshold_flag});
      vdd_mv <= 5000;
      wr(`LVD_IDX_CONTROL, 8'h00);
      n0 = irq_cnt;
      vdd_mv <= 4000;
      repeat (10) @(posedge ref_clk);
      check("irq disabled", 32'h0, 32'(irq_cnt - n0));
      rdc(`LVD_IDX_CONTROL, 32'h00, "flag off");
      vdd_mv <= 5000;
      $display("interrupt test ended");

      wr(`LVD_IDX_MASK, 8'h01);
      wr(`LVD_IDX_PORT12, 8'h00);
      wr(`LVD_IDX_LEVEL, 8'h05);
      wr(`LVD_IDX_CONTROL, 8'h80);
      settle();
      rdc(`LVD_IDX_CONTROL, 32'h80, "poll above");
      wr(`LVD_IDX_CONTROL, 8'h82);
      settle();
      check("no reset above", 32'h0, {31'h0, undervolt_reset});
      wr(`LVD_IDX_MASK, 8'h00);
      n0 = irq_cnt;
      vdd_mv <= 3000;
      settle();
      // level, direction and mask follow one edge after the reset
      repeat (2) @(posedge ref_clk);
      check("reset held", 32'h1, {31'h0, undervolt_reset});
      check("enable kept", 32'h1, {31'h0, detector_on});
      check("level cleared", 32'h0, {28'h0, threshold_code});
      check("dir set", 32'h1F, {27'h0, port12_dir});
      check("mask set", 32'h1, {31'h0, undervolt_irq_mask});
      vdd_mv <= 4240;
      settle();
      check("reset released", 32'h0, {31'h0, undervolt_reset});
      check("no irq in reset", 32'h0, 32'(irq_cnt - n0));
      rdc(`LVD_IDX_CAUSE, 32'h01, "cause set");
      rdc(`LVD_IDX_CONTROL, 32'h82, "control kept");
      wr(`LVD_IDX_CAUSE, 8'h01);
      rdc(`LVD_IDX_CAUSE, 32'h00, "cause cleared");
      wr(`LVD_IDX_CONTROL, 8'h80);
      wr(`LVD_IDX_CONTROL, 8'h00);
      rdc(`LVD_IDX_CONTROL, 32'h00, "stopped");
      vdd_mv <= 5000;
      $display("reset action test ended");

      wr(`LVD_IDX_LEVEL, 8'h0A);
      wr(`LVD_IDX_PORT12, 8'h00);
      wr(`LVD_IDX_MASK, 8'h00);
      wr(`LVD_IDX_CONTROL, 8'h84);
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      defaults();
      $display("second reset test ended");
      test_done();
   end
endmodule
